/* isro_consts.vh */
// constants for the image sensor readout and output block
// assumes the including file supplies the module context
`ifndef ISRO_CONSTS_VH
`define ISRO_CONSTS_VH
`define ISRO_ADC_W        12
`define ISRO_HDR_W        16
`define ISRO_OUT_W        16
`define ISRO_ACT_COLS     1920
`define ISRO_ACT_ROWS     1080
`define ISRO_HBLANK       280
`define ISRO_VBLANK       45
`define ISRO_EXPOSE_ROWS  16'h0200
`define ISRO_GAIN_UNITY   8'h20
`define ISRO_EMB_LINES    2
`define ISRO_ADDR_LOW     7'h10
`define ISRO_ADDR_HIGH    7'h18
`define ISRO_FMT_RAW12    2'h0
`define ISRO_FMT_ALAW10   2'h1
`define ISRO_FMT_COMP14   2'h2
`define ISRO_FMT_LIN16    2'h3
`define ISRO_BLACK_OFS    12'h0a8
`define ISRO_MIN_DIV      2
`endif

/* isro_compand.v */
// pixel companding functions: 16-bit merged to 12/14-bit codes, 12-bit to 10-bit
// assumes a pure combinational use inside the readout core
`timescale 1ns/10ps
`include "isro_consts.vh"
module isro_compand (
    input  wire [15:0] lin_in,      // linear merged or raw sample
    input  wire [1:0]  fmt,         // output word format
    input  wire        hdr,         // high dynamic range stream
    output reg  [15:0] code_out     // code, low aligned
);
    // piecewise log knee: leading-one position picks the segment
    function [11:0] comp16to12;
        input [15:0] v;
        integer i;
        reg [3:0] msb;
        begin
            msb = 4'h0;
            for (i = 0; i < 16; i = i + 1)
                if (v[i]) msb = i[3:0];
            if (msb < 4'h9)
                comp16to12 = {3'h0, v[8:0]};
            else
                comp16to12 = {msb - 4'h8, 8'h00} | {4'h0, v[msb - 4'h1 -: 8]};
        end
    endfunction
    // wider knee: keeps two more mantissa bits
    function [13:0] comp16to14;
        input [15:0] v;
        integer i;
        reg [3:0] msb;
        begin
            msb = 4'h0;
            for (i = 0; i < 16; i = i + 1)
                if (v[i]) msb = i[3:0];
            if (msb < 4'hb)
                comp16to14 = {3'h0, v[10:0]};
            else
                comp16to14 = {msb - 4'ha, 10'h000} | {4'h0, v[msb - 4'h1 -: 10]};
        end
    endfunction
    // a-law style 12 to 10 bit: linear low end, log segments above
    function [9:0] alaw12to10;
        input [11:0] v;
        begin
            if (v[11])      alaw12to10 = {3'h7, v[10:4]};
            else if (v[10]) alaw12to10 = {3'h6, v[9:3]};
            else if (v[9])  alaw12to10 = {3'h5, v[8:2]};
            else if (v[8])  alaw12to10 = {3'h4, v[7:1]};
            else            alaw12to10 = {2'h0, v[7:0]};
        end
    endfunction
    // format select
    always @* begin
        code_out = 16'h0000;
        case (fmt)
            `ISRO_FMT_RAW12:  code_out = hdr ? {4'h0, comp16to12(lin_in)} : {4'h0, lin_in[11:0]};
            `ISRO_FMT_ALAW10: code_out = {6'h00, alaw12to10(lin_in[11:0])};
            `ISRO_FMT_COMP14: code_out = {2'h0, comp16to14(lin_in)};
            `ISRO_FMT_LIN16:  code_out = lin_in;
            default:          code_out = 16'h0000;
        endcase
    end
endmodule

/* isro_core.v */
// readout sequencer, digital chain and output formatter of the sensor
// assumes clk is the pll-derived pixel clock; trig and addr pins are async
`timescale 1ns/10ps
`include "isro_consts.vh"
module isro_core #(
    parameter ACT_COLS  = `ISRO_ACT_COLS,   // active pixels per line
    parameter ACT_ROWS  = `ISRO_ACT_ROWS,   // active lines per frame
    parameter HBLANK    = `ISRO_HBLANK,     // blank pixels per line
    parameter VBLANK    = `ISRO_VBLANK,     // blank lines per frame
    parameter EMB_LINES = `ISRO_EMB_LINES   // embedded lines top and bottom
) (
    input  wire        clk,                 // master-derived pixel rate clock
    input  wire        resetn,              // async active low reset
    input  wire [11:0] adc_sample,          // converter sample of current pixel
    input  wire [11:0] adc_sample_short,    // short exposure sample, hdr
    input  wire        hdr_enable,          // merge two exposures
    input  wire        compress_enable,     // compress hdr output
    input  wire        parallel_select,     // 1 parallel port, 0 serial port
    input  wire [1:0]  word_format,         // output word format
    input  wire        trigger_mode,        // single frame trigger mode
    input  wire        trigger_pin,         // exposure synchronization pin
    input  wire        bus_address_select,  // two-wire address select pin
    input  wire        embed_enable,        // insert embedded data lines
    input  wire [15:0] expose_rows,         // reset-to-read delay in rows
    input  wire [7:0]  digital_gain,        // gain, 3.5 fixed point
    input  wire [11:0] black_offset,        // black level subtracted
    input  wire [15:0] embed_word,          // register / histogram word
    input  wire [15:0] hdr_ratio_shift,     // exposure ratio as shift, low 4 bits
    output reg  [15:0] pixel_data,          // output word
    output reg         frame_window,        // frame valid flag
    output reg         line_window,         // line valid flag
    output reg         pixel_out_clock,     // parallel pixel clock out
    output reg         serial_valid,        // word valid for serial lanes
    output reg  [6:0]  bus_address,         // two-wire device address
    output reg  [11:0] row_reset_addr,      // row being reset
    output reg         row_reset_strobe,    // reset pulse for that row
    output reg  [11:0] row_read_addr,       // row being read
    output reg         row_read_strobe,     // read pulse for that row
    output reg         busy                 // frame in progress
);
    localparam ST_IDLE  = 2'h0;   // waiting for trigger
    localparam ST_RUN   = 2'h1;   // streaming frame
    localparam ST_LAST  = 2'h2;   // last frame then idle
    localparam LINE_LEN = ACT_COLS + HBLANK;
    localparam FRM_LEN  = ACT_ROWS + VBLANK;

    // reset release synchroniser
    reg        rst_a_reg;
    reg        rst_b_reg;
    wire       rstn = rst_b_reg;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_a_reg <= 1'b0;
            rst_b_reg <= 1'b0;
        end else begin
            rst_a_reg <= 1'b1;
            rst_b_reg <= rst_a_reg;
        end
    end

    // pin synchronisers, two flops before use
    reg        trig_s1_reg;
    reg        trig_s2_reg;
    reg        trig_d_reg;       // for edge detect
    reg        addr_s1_reg;
    reg        addr_s2_reg;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            trig_s1_reg <= 1'b0;
            trig_s2_reg <= 1'b0;
            trig_d_reg  <= 1'b0;
            addr_s1_reg <= 1'b0;
            addr_s2_reg <= 1'b0;
        end else begin
            trig_s1_reg <= trigger_pin;
            trig_s2_reg <= trig_s1_reg;
            trig_d_reg  <= trig_s2_reg;
            addr_s1_reg <= bus_address_select;
            addr_s2_reg <= addr_s1_reg;
        end
    end
    wire trig_rise = trig_s2_reg & ~trig_d_reg;

    // address select chooses the 8-bit 0x20 / 0x30 write address
    always @(posedge clk or negedge rstn) begin
        if (!rstn)
            bus_address <= `ISRO_ADDR_LOW;
        else
            bus_address <= addr_s2_reg ? `ISRO_ADDR_HIGH : `ISRO_ADDR_LOW;
    end

    // parallel port runs at half rate: two clk per pixel keeps under 74.25 MHz
    reg        div_reg;
    always @(posedge clk or negedge rstn) begin
        if (!rstn)
            div_reg <= 1'b0;
        else
            div_reg <= parallel_select ? ~div_reg : 1'b1;
    end
    wire pix_step = div_reg;    // one pixel step per enable

    // frame state: video runs free, trigger mode runs one frame
    reg [1:0]  state_reg;
    reg [1:0]  state_next;
    reg [11:0] col_reg;
    reg [11:0] row_reg;
    wire       line_end  = pix_step && (col_reg == LINE_LEN - 1);
    wire       frame_end = line_end && (row_reg == FRM_LEN - 1);
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: if (!trigger_mode || trig_rise) state_next = trigger_mode ? ST_LAST : ST_RUN;
            ST_RUN:  if (frame_end && trigger_mode) state_next = ST_IDLE;
            ST_LAST: if (frame_end) state_next = trigger_mode ? ST_IDLE : ST_RUN;
            default: state_next = ST_IDLE;
        endcase
    end
    wire running = (state_reg != ST_IDLE);
    always @(posedge clk or negedge rstn) begin
        if (!rstn)
            state_reg <= ST_IDLE;
        else
            state_reg <= state_next;
    end

    // progressive raster counters at fixed totals give constant frame rate
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            col_reg <= 12'h000;
            row_reg <= 12'h000;
        end else if (!running) begin
            col_reg <= 12'h000;
            row_reg <= 12'h000;
        end else if (pix_step) begin
            if (line_end) begin
                col_reg <= 12'h000;
                row_reg <= frame_end ? 12'h000 : row_reg + 12'h001;
            end else begin
                col_reg <= col_reg + 12'h001;
            end
        end
    end

    // rolling shutter: reset row leads read row by the exposure in rows
    wire [15:0] ahead = {4'h0, row_reg} + expose_rows;
    wire [15:0] wrap  = (ahead >= FRM_LEN) ? ahead - FRM_LEN[15:0] : ahead;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            row_read_addr    <= 12'h000;
            row_read_strobe  <= 1'b0;
            row_reset_addr   <= 12'h000;
            row_reset_strobe <= 1'b0;
        end else begin
            row_read_strobe  <= running && pix_step && (col_reg == 12'h000) && (row_reg < ACT_ROWS);
            row_read_addr    <= row_reg;
            row_reset_strobe <= running && pix_step && (col_reg == 12'h000) && (wrap < ACT_ROWS);
            row_reset_addr   <= wrap[11:0];
        end
    end

    // digital chain: black offset, gain, hdr merge
    function [15:0] gain_apply;
        input [11:0] s;
        input [11:0] blk;
        input [7:0]  g;
        reg   [11:0] d;
        reg   [19:0] p;
        begin
            d = (s > blk) ? s - blk : 12'h000;
            p = d * g;
            gain_apply = (p[19:5] > 15'h0fff) ? 16'h0fff : {4'h0, p[16:5]};
        end
    endfunction
    wire [15:0] long_c  = gain_apply(adc_sample, black_offset, digital_gain);
    wire [15:0] short_c = gain_apply(adc_sample_short, black_offset, digital_gain);
    wire [15:0] short_s = short_c << hdr_ratio_shift[3:0];
    // long exposure until it saturates, then scaled short exposure
    wire [15:0] merged  = (hdr_enable && long_c[11:0] == 12'hfff) ? short_s : long_c;

    // format the word; hdr without compression streams 16-bit linear
    wire [1:0]  fmt_eff = (hdr_enable && !compress_enable) ? `ISRO_FMT_LIN16 :
                          (hdr_enable && parallel_select) ? `ISRO_FMT_RAW12 : word_format;
    wire [15:0] coded;
    isro_compand u_comp (
        .lin_in   (merged),
        .fmt      (fmt_eff),
        .hdr      (hdr_enable),
        .code_out (coded)
    );

    // window decode and embedded lines
    wire act_col = (col_reg < ACT_COLS);
    wire emb_row = (row_reg < EMB_LINES) || (row_reg >= ACT_ROWS - EMB_LINES);
    wire in_frm  = running && (row_reg < ACT_ROWS);

    // output stage, all from flops; data changes on clock fall so rise sees it
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pixel_data      <= 16'h0000;
            frame_window    <= 1'b0;
            line_window     <= 1'b0;
            pixel_out_clock <= 1'b0;
            serial_valid    <= 1'b0;
            busy            <= 1'b0;
        end else begin
            busy            <= running;
            pixel_out_clock <= parallel_select & ~div_reg;
            if (pix_step) begin
                frame_window <= in_frm;
                line_window  <= in_frm && act_col;
                serial_valid <= !parallel_select && in_frm && act_col;
                if (in_frm && act_col)
                    pixel_data <= (embed_enable && emb_row) ? embed_word : coded;
                else
                    pixel_data <= 16'h0000;
            end
        end
    end
endmodule

/* isro_checker.sv */
// concurrent checks on the readout core output ports
// assumes it is bound onto isro_core running with a shrunk frame
`timescale 1ns/10ps
module isro_checker #(
    parameter ACT_COLS = 8          // active pixels per line
) (
    input wire        clk,
    input wire        resetn,
    input wire        parallel_select,
    input wire        trigger_mode,
    input wire        trigger_pin,
    input wire        bus_address_select,
    input wire [15:0] pixel_data,
    input wire        frame_window,
    input wire        line_window,
    input wire        pixel_out_clock,
    input wire        serial_valid,
    input wire [6:0]  bus_address,
    input wire        row_reset_strobe,
    input wire        row_read_strobe,
    input wire        busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    reg [15:0] run_reg;             // clocks the line flag has stood high
    // run length of the line flag, cleared as soon as it drops
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            run_reg <= 16'h0000;
        end else begin
            run_reg <= line_window ? run_reg + 16'h0001 : 16'h0000;
        end
    end
    property p_line_in_frame; line_window |-> frame_window; endproperty
    a_line_in_frame: assert property (p_line_in_frame) else $error("line flag outside frame");
    property p_line_len; $fell(line_window) |-> run_reg == ACT_COLS * (parallel_select ? 2 : 1); endproperty
    a_line_len: assert property (p_line_len) else $error("line length wrong");
    property p_addr; ($stable(bus_address_select))[*8] |-> bus_address == (bus_address_select ? 7'h18 : 7'h10);
    endproperty
    a_addr: assert property (p_addr) else $error("bus address does not follow select");
    property p_read_pulse; row_read_strobe |=> !row_read_strobe; endproperty
    a_read_pulse: assert property (p_read_pulse) else $error("read strobe too long");
    property p_reset_pulse; row_reset_strobe |=> !row_reset_strobe; endproperty
    a_reset_pulse: assert property (p_reset_pulse) else $error("reset strobe too long");
    property p_valid_frame; serial_valid |-> frame_window; endproperty
    a_valid_frame: assert property (p_valid_frame) else $error("serial word outside frame");
    property p_data_rise; (parallel_select && pixel_out_clock) |-> $stable(pixel_data); endproperty
    a_data_rise: assert property (p_data_rise) else $error("data moved while pixel clock high");
    property p_trig_idle; (trigger_mode && $fell(busy)) ##1 (trigger_mode && !trigger_pin)[*4] |-> !busy;
    endproperty
    a_trig_idle: assert property (p_trig_idle) else $error("frame started without trigger");
    c_frame: cover property ($rose(frame_window));
    c_par_line: cover property (parallel_select && $fell(line_window));
    c_trig: cover property (trigger_mode && $rose(busy));
endmodule
bind isro_core isro_checker #(.ACT_COLS(ACT_COLS)) u_isro_checker (.clk(clk), .resetn(resetn),
    .parallel_select(parallel_select), .trigger_mode(trigger_mode), .trigger_pin(trigger_pin),
    .bus_address_select(bus_address_select), .pixel_data(pixel_data), .frame_window(frame_window),
    .line_window(line_window), .pixel_out_clock(pixel_out_clock), .serial_valid(serial_valid),
    .bus_address(bus_address), .row_reset_strobe(row_reset_strobe), .row_read_strobe(row_read_strobe),
    .busy(busy));

/* isro_host_model.sv */
// host processor side: counts words, lines and frames it receives
// assumes flags and data are settled at the rising edge of clk
`timescale 1ns/10ps
module isro_host_model (
    input  wire        clk,
    input  wire        resetn,
    input  wire        frame_window,
    input  wire        line_window,
    input  wire        pixel_out_clock,
    input  wire        parallel_select,
    input  wire [15:0] pixel_data,
    output reg  [15:0] line_words,   // words in last finished line
    output reg  [15:0] frame_lines,  // lines in last finished frame
    output reg  [15:0] frame_cnt,    // finished frames
    output reg  [15:0] first_word    // first word of last frame
);
    reg [15:0] word_reg;             // words of current line
    reg [15:0] line_reg;             // lines of current frame
    reg        pclk_d, lw_d, fw_d;   // previous samples for edge finding
    reg        fresh_reg;            // no word taken yet this frame
    // parallel words only count on a pixel clock rise, serial every clk
    wire take = line_window && (parallel_select ? (pixel_out_clock && !pclk_d) : 1'b1);
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            {word_reg, line_reg, line_words, frame_lines, frame_cnt, first_word} <= 96'h0;
            {pclk_d, lw_d, fw_d, fresh_reg} <= 4'h1;
        end else begin
            pclk_d <= pixel_out_clock;
            lw_d <= line_window;
            fw_d <= frame_window;
            word_reg <= (line_window && !lw_d) ? {15'h0, take} : word_reg + {15'h0, take};
            if (line_window && !lw_d) line_reg <= line_reg + 16'h0001;
            if (lw_d && !line_window) line_words <= word_reg;
            if (take && fresh_reg) first_word <= pixel_data;
            fresh_reg <= take ? 1'b0 : (!frame_window | fresh_reg);
            // a frame closes on the falling frame flag
            if (fw_d && !frame_window) begin
                frame_lines <= line_reg;
                line_reg <= 16'h0000;
                frame_cnt <= frame_cnt + 16'h0001;
            end
        end
    end
endmodule

/* testbench.sv */
// self-checking bench for the readout core on a shrunk frame
// assumes the host model and the bound checker are compiled alongside
`timescale 1ns/10ps
module testbench;
    localparam [15:0] COLS = 16'h0008, ROWS = 16'h0006;
    reg         clk, resetn, hdr_enable, compress_enable, parallel_select, trigger_mode, trigger_pin;
    reg         bus_address_select, embed_enable;
    reg  [11:0] adc_sample, adc_sample_short;
    reg  [1:0]  word_format;
    reg  [15:0] embed_word, expose_rows, hdr_ratio_shift;
    reg  [7:0]  digital_gain;
    reg  [11:0] black_offset;
    wire [11:0] row_reset_addr, row_read_addr;
    wire        row_reset_strobe, row_read_strobe;
    reg  [31:0] rnd;
    wire [15:0] pixel_data, line_words, frame_lines, frame_cnt, first_word;
    wire [6:0]  bus_address;
    wire        frame_window, line_window, pixel_out_clock, serial_valid, busy;
    integer     error_cnt, checks_done, seed, i, n0;
    isro_core #(.ACT_COLS(8), .ACT_ROWS(6), .HBLANK(4), .VBLANK(3), .EMB_LINES(2)) u_isro_core (
        .clk(clk), .resetn(resetn), .adc_sample(adc_sample), .adc_sample_short(adc_sample_short),
        .hdr_enable(hdr_enable), .compress_enable(compress_enable), .parallel_select(parallel_select),
        .word_format(word_format), .trigger_mode(trigger_mode), .trigger_pin(trigger_pin),
        .bus_address_select(bus_address_select), .embed_enable(embed_enable), .expose_rows(expose_rows),
        .digital_gain(digital_gain), .black_offset(black_offset), .embed_word(embed_word),
        .hdr_ratio_shift(hdr_ratio_shift),
        .pixel_data(pixel_data), .frame_window(frame_window), .line_window(line_window),
        .pixel_out_clock(pixel_out_clock), .serial_valid(serial_valid), .bus_address(bus_address),
        .row_reset_addr(row_reset_addr), .row_reset_strobe(row_reset_strobe), .row_read_addr(row_read_addr),
        .row_read_strobe(row_read_strobe), .busy(busy));
    isro_host_model u_isro_host_model (.clk(clk), .resetn(resetn), .frame_window(frame_window),
        .line_window(line_window), .pixel_out_clock(pixel_out_clock), .parallel_select(parallel_select),
        .pixel_data(pixel_data), .line_words(line_words), .frame_lines(frame_lines),
        .frame_cnt(frame_cnt), .first_word(first_word));
    // compare one expected value with what was seen
    task check(input [15:0] exp, input [15:0] got);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
            end
        end
    endtask
    task results;
        begin
            $display("errors=%0d checks=%0d", error_cnt, checks_done);
            if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    // bounded wait for n more finished frames; a stall ends the run
    task wait_frames(input integer n);
        integer base, k;
        begin
            base = frame_cnt;
            for (k = 0; k < 4000 && frame_cnt < base + n; k = k + 1) @(posedge clk);
            if (frame_cnt < base + n) begin
                error_cnt = error_cnt + 1;
                results;
            end
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // fresh converter samples every clock from a fixed seed
    always @(posedge clk) begin
        rnd = $random(seed);
        adc_sample <= rnd[11:0];
        adc_sample_short <= rnd[23:12];
    end
    initial begin
        seed = 72366;
        {error_cnt, checks_done} = 0;
        {resetn, hdr_enable, compress_enable, parallel_select, trigger_mode, trigger_pin} = 6'h0;
        {bus_address_select, embed_enable, word_format, embed_word} = 20'h0;
        {adc_sample, adc_sample_short} = 24'h0;
        expose_rows = 16'h0002;
        hdr_ratio_shift = 16'h0002;
        digital_gain = 8'h20;
        black_offset = 12'h000;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        wait_frames(2);
        check(COLS, line_words);
        check(ROWS, frame_lines);
        check(16'h0010, {9'h0, bus_address});
        // every word format on the serial port keeps the line length
        for (i = 0; i < 4; i = i + 1) begin
            word_format <= i[1:0];
            wait_frames(2);
            check(COLS, line_words);
        end
        @(posedge clk);
        {hdr_enable, compress_enable, parallel_select, bus_address_select} <= 4'hf;
        word_format <= 2'h0;
        wait_frames(2);
        check(COLS, line_words);
        check(ROWS, frame_lines);
        check(16'h0018, {9'h0, bus_address});
        @(posedge clk);
        {hdr_enable, compress_enable, parallel_select, embed_enable} <= 4'h1;
        embed_word <= rnd[31:16];
        wait_frames(2);
        check(embed_word, first_word);
        @(posedge clk);
        {embed_enable, trigger_mode} <= 2'h1;
        for (i = 0; i < 4000 && busy !== 1'b0; i = i + 1) @(posedge clk);
        if (busy !== 1'b0) begin
            error_cnt = error_cnt + 1;
            results;
        end
        n0 = frame_cnt;
        repeat (300) @(posedge clk);
        check(n0[15:0], frame_cnt);
        trigger_pin <= 1'b1;
        repeat (4) @(posedge clk);
        trigger_pin <= 1'b0;
        wait_frames(1);
        repeat (300) @(posedge clk);
        check(n0[15:0] + 16'h0001, frame_cnt);
        results;
    end
endmodule
